// ==== src/etce_pkg.sv ====
package etce_pkg;

   // Command packet geometry
   localparam int unsigned PKT_BYTES   = 32;
   localparam int unsigned PKT_DWORDS  = 4;
   localparam int unsigned DW_W        = 64;

   // Opcodes in bits 7:0 of doubleword 0
   localparam logic [7:0] OPC_CLEAR    = 8'h04;
   localparam logic [7:0] OPC_DISCARD  = 8'h0F;
   localparam logic [7:0] OPC_INT      = 8'h03;
   localparam int unsigned OPC_LO      = 0;
   localparam int unsigned DEV_LO      = 32;
   localparam int unsigned EVT_LO      = 0;

   // Table geometry
   localparam int unsigned DEV_W       = 4;
   localparam int unsigned EVT_W       = 8;
   localparam int unsigned COL_W       = 4;
   localparam int unsigned INTID_W     = 16;
   localparam int unsigned VCORE_W     = 4;
   localparam int unsigned PTR_W       = 4;
   localparam int unsigned TGT_W       = 36;  // Address bits 51:16 when format is 1

   // Register offsets (word index)
   localparam logic [3:0] REG_CTRL     = 4'h0;
   localparam logic [3:0] REG_WPTR     = 4'h1;
   localparam logic [3:0] REG_RPTR     = 4'h2;
   localparam logic [3:0] REG_DEV      = 4'h3;
   localparam logic [3:0] REG_ITE      = 4'h4;
   localparam logic [3:0] REG_COL      = 4'h5;
   localparam logic [3:0] REG_VCORE    = 4'h6;
   localparam logic [3:0] REG_QLO      = 4'h7;
   localparam logic [3:0] REG_QHI      = 4'h8;
   localparam logic [3:0] REG_ERR      = 4'h9;

   // Field positions
   localparam int unsigned RETRY_BIT   = 31;
   localparam int unsigned STALL_BIT   = 31;
   localparam int unsigned VALID_BIT   = 31;

   // Error responses
   localparam logic [1:0] RESP_IGNORE  = 2'd0;
   localparam logic [1:0] RESP_STALL   = 2'd1;
   localparam logic [1:0] RESP_LEGAL   = 2'd2;

   // Error codes
   localparam logic [2:0] ERR_NONE     = 3'd0;
   localparam logic [2:0] ERR_DEV_OOR  = 3'd1;
   localparam logic [2:0] ERR_DEV_UNM  = 3'd2;
   localparam logic [2:0] ERR_EVT_OOR  = 3'd3;
   localparam logic [2:0] ERR_EVT_UNM  = 3'd4;
   localparam logic [2:0] ERR_COL_UNM  = 3'd5;
   localparam logic [2:0] ERR_AGENT    = 3'd6;

   // Pending-state agent request
   typedef struct packed {
      logic               set;
      logic               clr;
      logic               sync_cfg;
      logic [TGT_W-1:0]   target;
      logic [INTID_W-1:0] intid;
   } etce_agent_req_t;

endpackage : etce_pkg

// ==== src/etce_exec.sv ====
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
// What this block does
// - Command is four 64-bit doublewords, 32 bytes
// - Clear opcode 0x04; device high, event low
// - Clear translates, then agent clears pending
// - Set-pending translates, then agent sets pending
// - Five lookup failures count as command errors
// - Checks in order, act, agent error, advance
// - Ignore response: no action, pointer wraps forward
// - Stall response: pointer stays on bad entry
// - Stall sets stalled bit in read pointer
// - Retry bit write resumes at stalled entry
// - Legal response: execute on unmapped event or collection only, pointer advances
// - System error raised when support bit set
// - Discard clears pending and invalidates entry
// - Discard syncs agent cached configuration
// - Virtual core mapped nowhere: remove, keep pending
// - Virtual core unmapped unless mapped valid
// - Format 0 target is a core number
// - Virtual core range limited to table size
// - Format 1 target carries address bits 51:16
module etce_exec
   import etce_pkg::*;
(
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  nrst,
   // Register port
   input  wire logic [3:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output      logic [31:0]           reg_rdata,
   // Pending-state agent
   output      etce_agent_req_t       agent_req,
   input  wire logic                  agent_done,
   input  wire logic                  agent_ok,
   // Status
   output      logic                  system_error
);

   localparam int unsigned NDEV = 1 << DEV_W;
   localparam int unsigned NCOL = 1 << COL_W;
   localparam int unsigned NVC  = 1 << VCORE_W;
   localparam int unsigned NQ   = 1 << PTR_W;
   localparam int unsigned NITE = NDEV * 4;

   typedef enum logic [2:0] {S_IDLE, S_DEC, S_CHK, S_ACT, S_WAIT, S_DONE} etce_state_t;

   // Tables held in flip-flops
   logic [DW_W-1:0]    queue_r    [NQ*PKT_DWORDS];
   logic               dev_v_r    [NDEV];
   logic [EVT_W-1:0]   dev_size_r [NDEV];
   logic               ite_v_r    [NITE];
   logic               ite_virt_r [NITE];
   logic [COL_W-1:0]   ite_col_r  [NITE];
   logic [INTID_W-1:0] ite_int_r  [NITE];
   logic               col_v_r    [NCOL];
   logic [TGT_W-1:0]   col_tgt_r  [NCOL];
   logic               vc_v_r     [NVC];
   logic               vc_any_r   [NVC];
   logic [TGT_W-1:0]   vc_tgt_r   [NVC];

   logic [PTR_W-1:0]   wptr_r, rptr_r;
   logic               stall_r, sei_r, pta_r;
   logic [1:0]         resp_r;
   logic [2:0]         err_r;
   logic [31:0]        qlo_r;
   etce_state_t        st_r;
   logic [DW_W-1:0]    dw0_r, dw1_r;
   logic [2:0]         cerr_r;
   logic [5:0]         idx_r;
   etce_agent_req_t    req_r;
   logic               serr_r;
   logic [31:0]        rdata_r;
   logic               skip_r;

   // Entry index from device and event
   function automatic logic [5:0] ite_idx(input logic [DEV_W-1:0] d, input logic [EVT_W-1:0] e);
      ite_idx = {d, e[1:0]};
   endfunction : ite_idx

   // Pointer advance with wrap
   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = p + 1'b1;
   endfunction : ptr_inc

   logic [7:0]           opc;
   logic [31:0]          dev_full, evt_full;
   logic [DEV_W-1:0]     dev;
   logic [EVT_W-1:0]     evt;
   assign opc      = dw0_r[OPC_LO +: 8];
   assign dev_full = dw0_r[DEV_LO +: 32];
   assign evt_full = dw1_r[EVT_LO +: 32];
   assign dev      = dev_full[DEV_W-1:0];
   assign evt      = evt_full[EVT_W-1:0];

   // Ordered error check
   logic [2:0] chk;
   always_comb
   begin
      logic [5:0] k;
      k = ite_idx(dev, evt);
      if (dev_full >= 32'(NDEV))                      chk = ERR_DEV_OOR;
      else if (!dev_v_r[dev])                         chk = ERR_DEV_UNM;
      else if (evt_full > 32'(dev_size_r[dev]) || evt > 8'd3) chk = ERR_EVT_OOR;
      else if (!ite_v_r[k])                           chk = ERR_EVT_UNM;
      else if (!ite_virt_r[k] && !col_v_r[ite_col_r[k]]) chk = ERR_COL_UNM;
      else                                            chk = ERR_NONE;
   end

   // Command sequencer
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r   <= S_IDLE;
         rptr_r <= '0;
         stall_r <= 1'b0;
         dw0_r  <= '0;
         dw1_r  <= '0;
         cerr_r <= ERR_NONE;
         idx_r  <= '0;
         req_r  <= '0;
         serr_r <= 1'b0;
         err_r  <= ERR_NONE;
         skip_r <= 1'b0;
      end
      else
      begin
         req_r  <= '0;
         serr_r <= 1'b0;
         case (st_r)
            S_IDLE:
            begin
               if (reg_wr && reg_addr == REG_WPTR && reg_wdata[RETRY_BIT])
                  stall_r <= 1'b0;
               else if (!stall_r && rptr_r != wptr_r)
               begin
                  dw0_r <= queue_r[{rptr_r, 2'd0}];
                  dw1_r <= queue_r[{rptr_r, 2'd1}];
                  st_r  <= S_DEC;
               end
            end
            S_DEC:
            begin
               idx_r <= ite_idx(dev, evt);
               cerr_r <= chk;
               st_r  <= S_CHK;
            end
            S_CHK:
            begin
               skip_r <= 1'b0;
               if (cerr_r != ERR_NONE)
               begin
                  err_r  <= cerr_r;
                  serr_r <= sei_r;
                  if (resp_r == RESP_STALL)
                  begin
                     stall_r <= 1'b1;
                     st_r    <= S_IDLE;
                  end
                  else if (resp_r == RESP_LEGAL && cerr_r >= ERR_EVT_UNM)
                     st_r <= S_ACT;
                  else
                     st_r <= S_DONE;
               end
               else
                  st_r <= S_ACT;
            end
            S_ACT:
            begin
               req_r.intid  <= ite_int_r[idx_r];
               req_r.target <= ite_virt_r[idx_r] ? vc_tgt_r[ite_col_r[idx_r]]
                                                 : col_tgt_r[ite_col_r[idx_r]];
               if (opc == OPC_INT)
                  req_r.set <= 1'b1;
               else if (opc == OPC_CLEAR)
                  req_r.clr <= 1'b1;
               else if (opc == OPC_DISCARD)
               begin
                  // Pending kept only when the virtual core is mapped nowhere
                  req_r.clr      <= !(ite_virt_r[idx_r] && !vc_any_r[ite_col_r[idx_r]]);
                  req_r.sync_cfg <= 1'b1;
               end
               skip_r <= ite_virt_r[idx_r] && !vc_v_r[ite_col_r[idx_r]]
                         && opc != OPC_DISCARD;
               st_r <= (opc == OPC_INT || opc == OPC_CLEAR || opc == OPC_DISCARD)
                       ? S_WAIT : S_DONE;
            end
            S_WAIT:
            begin
               if (agent_done)
               begin
                  if (!agent_ok || skip_r)
                  begin
                     err_r  <= ERR_AGENT;
                     serr_r <= sei_r;
                  end
                  st_r <= S_DONE;
               end
            end
            S_DONE:
            begin
               rptr_r <= ptr_inc(rptr_r);
               st_r   <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // Translation entry invalidated by a discard
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < NITE; i++)
         begin
            ite_v_r[i]    <= 1'b0;
            ite_virt_r[i] <= 1'b0;
            ite_col_r[i]  <= '0;
            ite_int_r[i]  <= '0;
         end
      end
      else if (st_r == S_ACT && opc == OPC_DISCARD)
         ite_v_r[idx_r] <= 1'b0;
      else if (reg_wr && reg_addr == REG_ITE)
      begin
         ite_v_r[reg_wdata[29:24]]    <= reg_wdata[VALID_BIT];
         ite_virt_r[reg_wdata[29:24]] <= reg_wdata[30];
         ite_col_r[reg_wdata[29:24]]  <= reg_wdata[19:16];
         ite_int_r[reg_wdata[29:24]]  <= reg_wdata[15:0];
      end
   end

   // Software-loaded tables and configuration
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         wptr_r <= '0;
         sei_r  <= 1'b0;
         pta_r  <= 1'b0;
         resp_r <= RESP_IGNORE;
         qlo_r  <= '0;
         for (int i = 0; i < NDEV; i++)
         begin
            dev_v_r[i]    <= 1'b0;
            dev_size_r[i] <= '0;
         end
         for (int i = 0; i < NCOL; i++)
         begin
            col_v_r[i]   <= 1'b0;
            col_tgt_r[i] <= '0;
         end
         for (int i = 0; i < NVC; i++)
         begin
            vc_v_r[i]   <= 1'b0;
            vc_any_r[i] <= 1'b0;
            vc_tgt_r[i] <= '0;
         end
         for (int i = 0; i < NQ*PKT_DWORDS; i++)
            queue_r[i] <= '0;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            REG_CTRL:
            begin
               sei_r  <= reg_wdata[0];
               pta_r  <= reg_wdata[1];
               resp_r <= reg_wdata[3:2];
            end
            REG_WPTR:  wptr_r <= reg_wdata[PTR_W-1:0];
            REG_DEV:
            begin
               dev_v_r[reg_wdata[27:24]]    <= reg_wdata[VALID_BIT];
               dev_size_r[reg_wdata[27:24]] <= reg_wdata[EVT_W-1:0];
            end
            REG_COL:
            begin
               col_v_r[reg_wdata[27:24]]   <= reg_wdata[VALID_BIT];
               col_tgt_r[reg_wdata[27:24]] <= TGT_W'(reg_wdata[23:0]);
            end
            REG_VCORE:
               if (reg_wdata[27:24] < 4'(NVC - 1) || reg_wdata[27:24] == 4'(NVC - 1))
               begin
                  vc_v_r[reg_wdata[27:24]]   <= reg_wdata[VALID_BIT];
                  vc_any_r[reg_wdata[27:24]] <= reg_wdata[VALID_BIT] | reg_wdata[30];
                  vc_tgt_r[reg_wdata[27:24]] <= TGT_W'(reg_wdata[23:0]);
               end
            REG_QLO:   qlo_r <= reg_wdata;
            REG_QHI:   queue_r[reg_wdata[31:26]] <= {6'h00, reg_wdata[25:0], qlo_r};
            default: ;
         endcase
      end
   end

   // Read data one cycle after the strobe
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         rdata_r <= '0;
      else if (reg_rd)
      begin
         case (reg_addr)
            REG_CTRL: rdata_r <= {28'h000_0000, resp_r, pta_r, sei_r};
            REG_WPTR: rdata_r <= {28'h000_0000, wptr_r};
            REG_RPTR: rdata_r <= {stall_r, 27'h000_0000, rptr_r};
            REG_ERR:  rdata_r <= {29'h0000_0000, err_r};
            default:  rdata_r <= '0;
         endcase
      end
      else
         rdata_r <= '0;
   end

   assign reg_rdata    = rdata_r;
   assign agent_req    = req_r;
   assign system_error = serr_r;

   // Checks
   property p_stall_hold;
      @(posedge clock) disable iff (!nrst)
      (st_r == S_CHK && cerr_r != ERR_NONE && resp_r == RESP_STALL)
         |=> stall_r && $stable(rptr_r);
   endproperty
   a_stall_hold: assert property (p_stall_hold) else $error("stall not held");

   // Ignore path: error found at the check step, then no request and a one-step advance
   sequence s_ignore_err;
      st_r == S_CHK && cerr_r != ERR_NONE && resp_r == RESP_IGNORE;
   endsequence

   sequence s_skip_advance;
      !req_r.set && !req_r.clr ##1 rptr_r == $past(rptr_r, 2) + 1'b1;
   endsequence

   property p_ignore_adv;
      @(posedge clock) disable iff (!nrst)
      s_ignore_err |=> s_skip_advance;
   endproperty
   a_ignore_adv: assert property (p_ignore_adv) else $error("ignore path wrong");

   property p_serr;
      @(posedge clock) disable iff (!nrst)
      system_error |-> sei_r;
   endproperty
   a_serr: assert property (p_serr) else $error("system error without support");

   property p_set;
      @(posedge clock) disable iff (!nrst)
      req_r.set |-> $past(st_r) == S_ACT && opc == OPC_INT;
   endproperty
   a_set: assert property (p_set) else $error("set without command");

   property p_clear;
      @(posedge clock) disable iff (!nrst)
      (st_r == S_ACT && opc == OPC_CLEAR) |=> req_r.clr;
   endproperty
   a_clear: assert property (p_clear) else $error("clear not issued");

   property p_discard;
      @(posedge clock) disable iff (!nrst)
      (st_r == S_ACT && opc == OPC_DISCARD) |=> !ite_v_r[$past(idx_r)] && req_r.sync_cfg;
   endproperty
   a_discard: assert property (p_discard) else $error("discard incomplete");

   property p_order;
      @(posedge clock) disable iff (!nrst)
      $changed(rptr_r) |-> $past(st_r) == S_DONE;
   endproperty
   a_order: assert property (p_order) else $error("pointer moved early");

   property p_stall_flag;
      @(posedge clock) disable iff (!nrst)
      $rose(stall_r) |-> $past(st_r) == S_CHK && resp_r == RESP_STALL;
   endproperty
   a_stall_flag: assert property (p_stall_flag) else $error("stray stall");

endmodule : etce_exec

// ==== bench/etce_agent.sv ====
`timescale 1ns/10ps
module etce_agent
   import etce_pkg::*;
(
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            nrst,
   // Request and answer
   input  wire etce_agent_req_t agent_req,
   output logic                 agent_done,
   output logic                 agent_ok,
   // Bench control and view
   input  wire logic [2:0]      dly,
   input  wire logic            fail,
   output etce_agent_req_t      last_r,
   output logic [7:0]           n_set,
   output logic [7:0]           n_clr,
   output logic [7:0]           n_syn
);
   logic [3:0] wait_r;
   logic       tog_r;

   // Take a request, count it, answer dly+1 cycles later
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         wait_r <= '0;
         tog_r <= 1'b0;
         agent_done <= 1'b0;
         last_r <= '0;
         n_set <= '0;
         n_clr <= '0;
         n_syn <= '0;
      end
      else
      begin
         tog_r <= ~tog_r;
         agent_done <= wait_r == 4'h1;
         if (wait_r != 4'h0)
            wait_r <= wait_r - 4'h1;
         if (agent_req.set | agent_req.clr | agent_req.sync_cfg)
         begin
            last_r <= agent_req;
            wait_r <= {1'b0, dly} + 4'h1;
            n_set <= n_set + 8'(agent_req.set);
            n_clr <= n_clr + 8'(agent_req.clr);
            n_syn <= n_syn + 8'(agent_req.sync_cfg);
         end
      end
   end

   // Outcome only means something beside done; otherwise it keeps moving
   assign agent_ok = agent_done ? ~fail : tog_r;
endmodule : etce_agent

// ==== bench/event_translation_cmd_exec_test.sv ====
`timescale 1ns/10ps
module event_translation_cmd_exec_test
   import etce_pkg::*;
;
   // Design and peer signals
   logic            clock, agent_done, agent_ok, system_error;
   logic            nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fail = 1'b0, vskip = 1'b0;
   logic [3:0]      reg_addr = 4'h0, wp = 4'h0;
   logic [31:0]     reg_wdata = 32'h0000_0000, reg_rdata;
   logic [2:0]      dly = 3'h0;
   logic [7:0]      n_set, n_clr, n_syn;
   etce_agent_req_t agent_req, last_r;
   // Tables as programmed, mode, case lists, counters
   logic            iv[4] = '{default: 1'b0};
   logic [15:0]     iid[4];
   logic [3:0]      icol[4] = '{default: 4'h0};
   logic            cv[16] = '{default: 1'b0};
   logic [23:0]     tgt;
   logic [1:0]      resp;
   logic            system_error_support;
   logic [7:0]      op[3] = '{OPC_CLEAR, OPC_INT, OPC_DISCARD};
   logic [3:0]      ra[5] = '{REG_CTRL, REG_WPTR, REG_RPTR, REG_ERR, 4'hF};
   int              cd[6] = '{1, 16, 2, 1, 1, 1};
   int              ce[6] = '{0, 0, 9, 4, 1, 2};
   int              n_mismatch = 0, n_tests = 0, n_serr = 0, cyc = 0, seed = 53;

   etce_exec DUT (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .agent_req(agent_req),
      .agent_done(agent_done), .agent_ok(agent_ok), .system_error(system_error));
   etce_agent PEER (.clock(clock), .nrst(nrst), .agent_req(agent_req),
      .agent_done(agent_done), .agent_ok(agent_ok), .dly(dly), .fail(fail),
      .last_r(last_r), .n_set(n_set), .n_clr(n_clr), .n_syn(n_syn));

   // 50 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Count system error pulses and cut a hang short
   always @(posedge clock)
   begin
      n_serr += system_error === 1'b1;
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic summarize();
      $display("counts tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   task automatic chk(logic [63:0] seen, logic [63:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(logic [3:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic mode(logic [1:0] r, logic s);
      resp = r;
      system_error_support = s;
      wr(REG_CTRL, {28'h000_0000, r, 1'b0, s});
   endtask : mode

   // Map event e of device 1 to collection c with a fresh identifier
   task automatic ite(logic [1:0] e, logic [3:0] c);
      logic [15:0] id;
      id = 16'($random(seed));
      iv[e] = 1'b1;
      icol[e] = c;
      iid[e] = id;
      wr(REG_ITE, {1'b1, 1'b0, 4'h1, e, 4'h0, c, id});
   endtask : ite

   // Expected error, checks taken in fixed order; only device 1 is mapped
   function automatic logic [2:0] exp_err(logic [31:0] d, logic [31:0] e);
      if (d > 15) return ERR_DEV_OOR;
      if (d != 1) return ERR_DEV_UNM;
      if (e > 3) return ERR_EVT_OOR;
      if (!iv[e[1:0]]) return ERR_EVT_UNM;
      if (!cv[icol[e[1:0]]]) return ERR_COL_UNM;
      return ERR_NONE;
   endfunction : exp_err

   // Poll until the read pointer leaves entry at or the queue stalls
   task automatic settle(logic [3:0] at);
      logic [31:0] v;
      repeat (40)
      begin
         rd(REG_RPTR, v);
         if (v[3:0] != at || v[STALL_BIT])
            break;
      end
   endtask : settle

   // Write a packet at the write pointer, publish it and wait
   task automatic run(logic [7:0] opc, logic [31:0] d, logic [31:0] e);
      logic [63:0] w[4];
      logic [3:0]  at;
      w = '{{d, 24'h00_0000, opc}, {32'h0000_0000, e}, 64'h0, 64'h0};
      at = wp;
      for (int i = 0; i < 4; i++)
      begin
         wr(REG_QLO, w[i][31:0]);
         wr(REG_QHI, {at, 2'(i), w[i][57:32]});
      end
      wp = wp + 4'h1;
      wr(REG_WPTR, {28'h000_0000, wp});
      settle(at);
   endtask : run

   // Run one command and check pointer, status, agent traffic
   task automatic go(logic [7:0] opc, logic [31:0] d, logic [31:0] e);
      logic [2:0]  er;
      logic        act, bad, stl;
      logic [31:0] v;
      logic [7:0]  s0, c0, y0;
      int          e0;
      s0 = n_set;
      c0 = n_clr;
      y0 = n_syn;
      e0 = n_serr;
      run(opc, d, e);
      er = exp_err(d, e);
      act = er == ERR_NONE || (resp == RESP_LEGAL && er > ERR_EVT_OOR);
      if (er == ERR_NONE && (fail || vskip))
         er = ERR_AGENT;
      bad = er != ERR_NONE;
      stl = bad && resp == RESP_STALL;
      rd(REG_RPTR, v);
      chk(v[3:0], stl ? wp - 4'h1 : wp);
      chk(v[STALL_BIT], stl);
      chk(n_serr - e0, bad && system_error_support);
      chk(n_set - s0, act && opc == OPC_INT);
      chk(n_clr - c0, act && opc != OPC_INT);
      if (bad)
      begin
         rd(REG_ERR, v);
         chk(v[2:0], er);
      end
      if (act && opc == OPC_DISCARD)
      begin
         chk(n_syn != y0, 1'b1);
         iv[e[1:0]] = 1'b0;
      end
      if (er == ERR_NONE)
      begin
         chk(last_r.intid, iid[e[1:0]]);
         chk(last_r.target, {12'h000, tgt});
      end
   endtask : go

   // Main sequence
   initial
   begin
      logic [31:0] v;
      logic [7:0]  c0;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      foreach (ra[i])
      begin
         rd(ra[i], v);
         chk(v, 32'h0000_0000);
      end
      $display("test reset done");
      mode(RESP_IGNORE, 1'b1);
      tgt = 24'($random(seed));
      wr(REG_DEV, 32'h8100_0003);
      wr(REG_COL, {8'h82, tgt});
      cv[2] = 1'b1;
      ite(2'd2, 4'd3);
      foreach (op[i])
      begin
         ite(2'd0, 4'd2);
         go(op[i], 1, 0);
      end
      $display("test commands done");
      for (int k = 1; k < 6; k++)
         go(op[k % 3], cd[k], ce[k]);
      go(OPC_INT, 1, 0);
      $display("test ignore done");
      mode(RESP_STALL, 1'b1);
      go(OPC_CLEAR, 1, 2);
      wr(REG_COL, {8'h83, tgt});
      cv[3] = 1'b1;
      c0 = n_clr;
      wr(REG_WPTR, {1'b1, 27'h000_0000, wp});
      settle(wp - 4'h1);
      rd(REG_RPTR, v);
      chk(v, {28'h000_0000, wp});
      chk(n_clr - c0, 8'h01);
      chk(last_r.intid, iid[2]);
      wr(REG_COL, 32'h0300_0000);
      cv[3] = 1'b0;
      $display("test stall done");
      mode(RESP_LEGAL, 1'b1);
      go(OPC_INT, 1, 2);
      go(OPC_CLEAR, 2, 9);
      mode(RESP_IGNORE, 1'b1);
      fail <= 1'b1;
      ite(2'd0, 4'd2);
      go(OPC_CLEAR, 1, 0);
      fail <= 1'b0;
      $display("test legal and agent error done");
      for (int k = 0; k < 24; k++)
      begin
         mode(1'($random(seed)) ? RESP_LEGAL : RESP_IGNORE, 1'($random(seed)));
         dly <= 3'($random(seed));
         if (1'($random(seed)))
            ite(2'(k), 4'(2 + k % 2));
         go(op[{$random(seed)} % 3], cd[{$random(seed)} % 6], ce[k % 6]);
      end
      $display("test random done");
      // Virtual entry on event 3: own target, core gone here, then core mapped nowhere
      mode(RESP_IGNORE, 1'b1);
      tgt = 24'($random(seed));
      wr(REG_VCORE, {8'h82, tgt});
      iv[3] = 1'b1;
      icol[3] = 4'd2;
      iid[3] = 16'($random(seed));
      wr(REG_ITE, {2'b11, 4'h1, 2'd3, 4'h0, 4'h2, iid[3]});
      go(OPC_INT, 1, 3);
      vskip = 1'b1;
      wr(REG_VCORE, {8'h42, tgt});
      go(OPC_CLEAR, 1, 3);
      vskip = 1'b0;
      wr(REG_VCORE, 32'h0200_0000);
      c0 = n_clr;
      run(OPC_DISCARD, 1, 3);
      chk(n_clr - c0, 8'h00);
      chk(last_r.sync_cfg, 1'b1);
      iv[3] = 1'b0;
      go(OPC_INT, 1, 3);
      $display("test virtual done");
      summarize();
   end
endmodule : event_translation_cmd_exec_test
